// ### cdu_pkg.sv
package cdu_pkg;

    // ************************************************************
    // Configuration set layout.
    // ************************************************************
    localparam int          CFG_WORDS   = 8;
    localparam int          IDX_W       = 3;
    localparam int          DATA_W      = 8;
    localparam int          PAGE_W      = 4;
    localparam logic [IDX_W-1:0] LAST_IDX  = 3'h7;
    localparam logic [IDX_W-1:0] MARGIN_IDX = 3'h0;
    localparam logic [IDX_W-1:0] UPPER_IDX  = 3'h1;
    localparam logic [IDX_W-1:0] LOWER_IDX  = 3'h2;

    // ************************************************************
    // Register offsets and bit positions.
    // ************************************************************
    localparam logic [7:0]  UPD_ADDR    = 8'h90;
    localparam logic [7:0]  RELOAD_ADDR = 8'hd8;
    localparam int          TRANSP_BIT  = 0;
    localparam int          COMMIT_BIT  = 1;
    localparam int          ERASE_BIT   = 2;
    localparam int          RELOAD_BIT  = 0;
    localparam logic [7:0]  RESET_WORD  = 8'h00;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int          CLK_NS      = 8;
    localparam int          SEQ_DLY_NS  = 500000;
    localparam int          SEQ_CYCLES  = SEQ_DLY_NS / CLK_NS;
    localparam int          SEQ_CNT_W   = 17;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_FETCH = 5'h02,
        ST_XFER  = 5'h04,
        ST_WAIT  = 5'h08,
        ST_RUN   = 5'h10
    } cdu_fsm_t;

    typedef struct packed {
        logic                valid;
        logic                write;
        logic [7:0]          addr;
        logic [DATA_W-1:0]   wdata;
    } cdu_acc_t;

    typedef struct packed {
        cdu_fsm_t                            fsm;
        logic                                sync_a;
        logic                                sync_b;
        logic [IDX_W-1:0]                    idx;
        logic                                rd_pend;
        logic                                got;
        logic [CFG_WORDS-1:0][DATA_W-1:0]    stage;
        logic [CFG_WORDS-1:0][DATA_W-1:0]    active;
        logic                                transp;
        logic                                erase_en;
        logic                                commit;
        logic                                copy_pend;
        logic [IDX_W-1:0]                    copy_idx;
        logic                                done;
        logic                                booted;
        logic [SEQ_CNT_W-1:0]                seq_cnt;
        logic                                seq_pulse;
        logic                                erase_pulse;
        logic [PAGE_W-1:0]                   erase_page;
        logic [DATA_W-1:0]                   rdata;
        logic [DATA_W-1:0]                   dac;
        logic                                dac_oe;
    } cdu_state_t;

endpackage : cdu_pkg

// ### cdu_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Margin code passes when within limits, else clamped to the violated limit.
// - Margin output is three-stated whenever lower limit exceeds upper limit.
// - Both code limits belong to the set fetched from nonvolatile memory at startup.
// - Download starts only after the supply lockout indication reports supply good.
// - At startup, every nonvolatile word lands in staging before any active word changes.
// - After staging fills, all staging words move to active in one step.
// - First sequencer state is loaded a fixed 0.5 ms after download completes.
// - Any serial access before download completion is not acknowledged.
// - An update writes the staging word first, then the active word.
// - Transparent bit set makes serial configuration writes take effect immediately.
// - Transparent bit clear writes only staging; active configuration stays unchanged.
// - Writing one to commit bit pulses once, loading all active words together.
// - With erase enabled, a page erase command sets the whole page to ones.
// - With erase disabled, a page erase command leaves the page untouched.
// - Configuration holds until host orders a reload, which restores stored settings.
// - Setting the reload bit in the run state (ST_RUN) copies nonvolatile configuration into RAM again.
module cdu_top #(
    parameter int SEQ_CYCLES = cdu_pkg::SEQ_CYCLES
) (
    // Clock and reset.
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    // Supply lockout indication, high when supply is good.
    input  wire logic                          supply_ok_i,
    // Serial register access.
    input  wire cdu_pkg::cdu_acc_t             acc_i,
    output logic                               acc_ack_o,
    output logic                               acc_nack_o,
    output logic [cdu_pkg::DATA_W-1:0]         acc_rdata_o,
    // Nonvolatile memory port.
    output logic                               nv_rd_o,
    output logic [cdu_pkg::IDX_W-1:0]          nv_addr_o,
    input  wire logic [cdu_pkg::DATA_W-1:0]    nv_rdata_i,
    input  wire logic                          page_erase_i,
    input  wire logic [cdu_pkg::PAGE_W-1:0]    page_i,
    output logic                               nv_erase_o,
    output logic [cdu_pkg::PAGE_W-1:0]         nv_erase_page_o,
    // Configuration and margining outputs.
    output logic [cdu_pkg::CFG_WORDS-1:0][cdu_pkg::DATA_W-1:0] active_cfg_o,
    output logic [cdu_pkg::DATA_W-1:0]         margin_code_o,
    output logic                               margin_oe_o,
    output logic                               seq_load_o,
    output logic                               download_done_o
);

    // ************************************************************
    // Local sizes.
    // ************************************************************
    localparam int CNT_W = cdu_pkg::SEQ_CNT_W;

    // ************************************************************
    // Helpers.
    // ************************************************************
    function automatic logic is_cfg(input logic [7:0] a);
        is_cfg = (a < 8'(cdu_pkg::CFG_WORDS));
    endfunction : is_cfg

    function automatic logic [cdu_pkg::DATA_W-1:0] clamp(input logic [cdu_pkg::DATA_W-1:0] code,
                                                         input logic [cdu_pkg::DATA_W-1:0] lo,
                                                         input logic [cdu_pkg::DATA_W-1:0] hi);
        if (code < lo) begin
            clamp = lo;
        end else if (code > hi) begin
            clamp = hi;
        end else begin
            clamp = code;
        end
    endfunction : clamp

    cdu_pkg::cdu_state_t cur_ff;
    cdu_pkg::cdu_state_t nxt_cur;

    logic acc_wr;
    logic acc_rd;
    assign acc_wr = acc_i.valid && acc_i.write && cur_ff.done;
    assign acc_rd = acc_i.valid && !acc_i.write && cur_ff.done;

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.sync_a = supply_ok_i;
        nxt_cur.sync_b = cur_ff.sync_a;
        nxt_cur.commit = 1'b0;
        nxt_cur.seq_pulse = 1'b0;
        nxt_cur.erase_pulse = 1'b0;
        nxt_cur.rd_pend = 1'b0;
        nxt_cur.copy_pend = 1'b0;
        nxt_cur.got = cur_ff.rd_pend;
        if (cur_ff.copy_pend) begin
            nxt_cur.active[cur_ff.copy_idx] = cur_ff.stage[cur_ff.copy_idx];
        end
        if (cur_ff.commit) begin
            nxt_cur.active = cur_ff.stage;
        end
        case (cur_ff.fsm)
            cdu_pkg::ST_IDLE: begin
                if (cur_ff.sync_b) begin
                    nxt_cur.fsm = cdu_pkg::ST_FETCH;
                    nxt_cur.idx = '0;
                end
            end
            cdu_pkg::ST_FETCH: begin
                if (cur_ff.got) begin
                    nxt_cur.stage[cur_ff.idx] = nv_rdata_i;
                    if (cur_ff.idx == cdu_pkg::LAST_IDX) begin
                        nxt_cur.fsm = cdu_pkg::ST_XFER;
                    end else begin
                        nxt_cur.idx = cur_ff.idx + 3'h1;
                    end
                end else if (!cur_ff.rd_pend) begin
                    nxt_cur.rd_pend = 1'b1;
                end
            end
            cdu_pkg::ST_XFER: begin
                nxt_cur.active = cur_ff.stage;
                nxt_cur.done = 1'b1;
                nxt_cur.seq_cnt = '0;
                nxt_cur.fsm = cur_ff.booted ? cdu_pkg::ST_RUN : cdu_pkg::ST_WAIT;
            end
            cdu_pkg::ST_WAIT: begin
                if (cur_ff.seq_cnt == CNT_W'(SEQ_CYCLES - 1)) begin
                    nxt_cur.seq_pulse = 1'b1;
                    nxt_cur.booted = 1'b1;
                    nxt_cur.fsm = cdu_pkg::ST_RUN;
                end else begin
                    nxt_cur.seq_cnt = cur_ff.seq_cnt + 17'h1;
                end
            end
            cdu_pkg::ST_RUN: begin
                nxt_cur.fsm = cdu_pkg::ST_RUN;
            end
            default: begin
                nxt_cur.fsm = cdu_pkg::ST_IDLE;
            end
        endcase
        if (acc_wr) begin
            if (is_cfg(acc_i.addr) && cur_ff.fsm != cdu_pkg::ST_FETCH) begin
                nxt_cur.stage[acc_i.addr[cdu_pkg::IDX_W-1:0]] = acc_i.wdata;
                nxt_cur.copy_pend = cur_ff.transp;
                nxt_cur.copy_idx = acc_i.addr[cdu_pkg::IDX_W-1:0];
            end else if (acc_i.addr == cdu_pkg::UPD_ADDR) begin
                nxt_cur.transp = acc_i.wdata[cdu_pkg::TRANSP_BIT];
                nxt_cur.commit = acc_i.wdata[cdu_pkg::COMMIT_BIT];
                nxt_cur.erase_en = acc_i.wdata[cdu_pkg::ERASE_BIT];
            end else if (acc_i.addr == cdu_pkg::RELOAD_ADDR && acc_i.wdata[cdu_pkg::RELOAD_BIT]
                         && cur_ff.fsm == cdu_pkg::ST_RUN) begin
                nxt_cur.fsm = cdu_pkg::ST_FETCH;
                nxt_cur.idx = '0;
            end
        end
        if (acc_rd) begin
            if (is_cfg(acc_i.addr)) begin
                nxt_cur.rdata = cur_ff.stage[acc_i.addr[cdu_pkg::IDX_W-1:0]];
            end else if (acc_i.addr == cdu_pkg::UPD_ADDR) begin
                nxt_cur.rdata = cdu_pkg::RESET_WORD;
                nxt_cur.rdata[cdu_pkg::TRANSP_BIT] = cur_ff.transp;
                nxt_cur.rdata[cdu_pkg::ERASE_BIT] = cur_ff.erase_en;
            end else begin
                nxt_cur.rdata = cdu_pkg::RESET_WORD;
            end
        end
        if (page_erase_i && cur_ff.done && cur_ff.erase_en) begin
            nxt_cur.erase_pulse = 1'b1;
            nxt_cur.erase_page = page_i;
        end
        nxt_cur.dac = clamp(cur_ff.active[cdu_pkg::MARGIN_IDX], cur_ff.active[cdu_pkg::LOWER_IDX],
                            cur_ff.active[cdu_pkg::UPPER_IDX]);
        nxt_cur.dac_oe = !(cur_ff.active[cdu_pkg::LOWER_IDX] > cur_ff.active[cdu_pkg::UPPER_IDX]);
        if (!cur_ff.sync_b) begin
            nxt_cur.fsm = cdu_pkg::ST_IDLE;
            nxt_cur.done = 1'b0;
            nxt_cur.booted = 1'b0;
            nxt_cur.transp = 1'b0;
            nxt_cur.erase_en = 1'b0;
            nxt_cur.commit = 1'b0;
            nxt_cur.copy_pend = 1'b0;
            nxt_cur.rd_pend = 1'b0;
            nxt_cur.got = 1'b0;
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_ff <= '{fsm: cdu_pkg::ST_IDLE, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign acc_ack_o = acc_i.valid && cur_ff.done;
    assign acc_nack_o = acc_i.valid && !cur_ff.done;
    assign acc_rdata_o = cur_ff.rdata;
    assign nv_rd_o = cur_ff.rd_pend;
    assign nv_addr_o = cur_ff.idx;
    assign nv_erase_o = cur_ff.erase_pulse;
    assign nv_erase_page_o = cur_ff.erase_page;
    assign active_cfg_o = cur_ff.active;
    assign margin_code_o = cur_ff.dac;
    assign margin_oe_o = cur_ff.dac_oe;
    assign seq_load_o = cur_ff.seq_pulse;
    assign download_done_o = cur_ff.done;

    // ************************************************************
    // Checks.
    // ************************************************************
    logic [cdu_pkg::SEQ_CNT_W-1:0] since_done_ff;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_done_ff <= '0;
        end else if (cur_ff.fsm == cdu_pkg::ST_XFER) begin
            since_done_ff <= '0;
        end else if (since_done_ff != '1) begin
            since_done_ff <= since_done_ff + 17'h1;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    clamp_low_a: assert property (cur_ff.active[cdu_pkg::MARGIN_IDX] < cur_ff.active[cdu_pkg::LOWER_IDX]
        |=> margin_code_o == $past(cur_ff.active[cdu_pkg::LOWER_IDX]))
        else $error("margin code not clamped to lower");
    clamp_high_a: assert property (cur_ff.active[cdu_pkg::MARGIN_IDX] > cur_ff.active[cdu_pkg::UPPER_IDX]
        && cur_ff.active[cdu_pkg::MARGIN_IDX] >= cur_ff.active[cdu_pkg::LOWER_IDX]
        |=> margin_code_o == $past(cur_ff.active[cdu_pkg::UPPER_IDX]))
        else $error("margin code not clamped to upper");
    output_hiz_a: assert property (cur_ff.active[cdu_pkg::LOWER_IDX] > cur_ff.active[cdu_pkg::UPPER_IDX]
        |=> !margin_oe_o) else $error("margin output driven with crossed limits");
    output_on_a: assert property (cur_ff.active[cdu_pkg::LOWER_IDX] <= cur_ff.active[cdu_pkg::UPPER_IDX]
        |=> margin_oe_o) else $error("margin output off with ordered limits");

    start_gate_a: assert property (!cur_ff.sync_b |=> cur_ff.fsm == cdu_pkg::ST_IDLE && !download_done_o)
        else $error("download not held in lockout");
    fetch_gate_a: assert property (nv_rd_o |-> $past(cur_ff.sync_b))
        else $error("fetch without supply good");
    fetch_hold_a: assert property (cur_ff.fsm == cdu_pkg::ST_FETCH && !cur_ff.commit && !cur_ff.copy_pend
        |=> $stable(cur_ff.active)) else $error("active changed during fetch");
    stage_fill_a: assert property (cur_ff.fsm == cdu_pkg::ST_FETCH && cur_ff.got && cur_ff.sync_b
        |=> cur_ff.stage[$past(cur_ff.idx)] == $past(nv_rdata_i))
        else $error("fetched word not staged");
    xfer_all_a: assert property (cur_ff.fsm == cdu_pkg::ST_XFER && cur_ff.sync_b
        |=> active_cfg_o == $past(cur_ff.stage) && download_done_o) else $error("transfer incomplete");
    seq_delay_a: assert property (seq_load_o |-> since_done_ff == CNT_W'(SEQ_CYCLES))
        else $error("sequencer load at wrong delay");

    early_nack_a: assert property (acc_i.valid && !download_done_o |-> acc_nack_o && !acc_ack_o)
        else $error("early access acknowledged");
    ack_gate_a: assert property (acc_i.valid && download_done_o |-> acc_ack_o && !acc_nack_o)
        else $error("access after download not acknowledged");
    staged_first_a: assert property (acc_wr && is_cfg(acc_i.addr) && cur_ff.transp && cur_ff.sync_b
        && cur_ff.fsm != cdu_pkg::ST_FETCH |=> cur_ff.copy_pend
        && cur_ff.stage[cur_ff.copy_idx] == $past(acc_i.wdata)) else $error("staging not written first");
    transp_copy_a: assert property (cur_ff.copy_pend && !cur_ff.commit && cur_ff.fsm != cdu_pkg::ST_XFER
        |=> active_cfg_o[$past(cur_ff.copy_idx)] == $past(cur_ff.stage[cur_ff.copy_idx]))
        else $error("transparent write not copied");
    staged_only_a: assert property (acc_wr && is_cfg(acc_i.addr) && !cur_ff.transp && !cur_ff.copy_pend
        && !cur_ff.commit && cur_ff.fsm == cdu_pkg::ST_RUN && cur_ff.sync_b |=> $stable(cur_ff.active))
        else $error("staged write reached active");
    commit_pulse_a: assert property (acc_wr && acc_i.addr == cdu_pkg::UPD_ADDR
        && acc_i.wdata[cdu_pkg::COMMIT_BIT] && cur_ff.sync_b
        |=> cur_ff.commit ##1 (!cur_ff.commit || $past(acc_wr && acc_i.addr == cdu_pkg::UPD_ADDR))
        && active_cfg_o == $past(cur_ff.stage)) else $error("commit not a single loading pulse");
    commit_clear_a: assert property (acc_rd && acc_i.addr == cdu_pkg::UPD_ADDR
        |=> !acc_rdata_o[cdu_pkg::COMMIT_BIT])
        else $error("commit bit read back as one");

    erase_go_a: assert property (page_erase_i && download_done_o && cur_ff.erase_en
        |=> nv_erase_o && nv_erase_page_o == $past(page_i))
        else $error("enabled erase not issued");
    erase_gate_a: assert property (nv_erase_o |-> $past(cur_ff.erase_en) && $past(page_erase_i))
        else $error("erase without enable");
    reload_a: assert property (acc_wr && acc_i.addr == cdu_pkg::RELOAD_ADDR
        && acc_i.wdata[cdu_pkg::RELOAD_BIT]
        && cur_ff.fsm == cdu_pkg::ST_RUN && cur_ff.sync_b |=> cur_ff.fsm == cdu_pkg::ST_FETCH)
        else $error("reload not started");
    reload_quiet_a: assert property (cur_ff.fsm == cdu_pkg::ST_XFER && cur_ff.booted && cur_ff.sync_b
        |=> cur_ff.fsm == cdu_pkg::ST_RUN && !seq_load_o)
        else $error("reload disturbed the sequencer");

    // ************************************************************
    // Covers.
    // ************************************************************
    boot_c: cover property (seq_load_o);
    commit_c: cover property (cur_ff.commit ##1 !cur_ff.commit);
    reload_c: cover property (cur_ff.booted && cur_ff.fsm == cdu_pkg::ST_XFER);
    hiz_c: cover property (!margin_oe_o && download_done_o);
    erase_c: cover property (nv_erase_o);

endmodule : cdu_top
`default_nettype wire

// ### cdu_nv_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdu_nv_model #(
    parameter logic [63:0] INIT = 64'h0706050403208050
) (
    // Clock.
    input  wire logic                       clk_i,
    // Fetch port from the block.
    input  wire logic                       nv_rd_i,
    input  wire logic [cdu_pkg::IDX_W-1:0]  nv_addr_i,
    output logic      [cdu_pkg::DATA_W-1:0] nv_rdata_o,
    // Erase port from the block.
    input  wire logic                       erase_i,
    input  wire logic [cdu_pkg::PAGE_W-1:0] erase_page_i,
    // Direct host programming of stored words.
    input  wire logic                       host_wr_i,
    input  wire logic [cdu_pkg::IDX_W-1:0]  host_idx_i,
    input  wire logic [cdu_pkg::DATA_W-1:0] host_data_i
);
    logic [cdu_pkg::CFG_WORDS-1:0][cdu_pkg::DATA_W-1:0] mem;

    initial begin
        mem = INIT;
        nv_rdata_o = 8'h5a;
    end

    // ************************************************************
    // Word answer one cycle after the fetch strobe, garbage otherwise.
    // ************************************************************
    always @(posedge clk_i) begin
        if (nv_rd_i) begin
            nv_rdata_o <= mem[nv_addr_i];
        end else begin
            nv_rdata_o <= ~nv_rdata_o;
        end
        if (host_wr_i) begin
            mem[host_idx_i] <= host_data_i;
        end
        if (erase_i && erase_page_i == 4'h0) begin
            mem <= '1;
        end
    end
endmodule : cdu_nv_model
`default_nettype wire

// ### test_config_download_update.sv
`timescale 1ns/1ps
`default_nettype none
module test_config_download_update;
    localparam int          SEQ  = 20;
    localparam logic [63:0] INIT = 64'h0706050403208050;

    logic                  clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  supply_ok = 1'b0;
    cdu_pkg::cdu_acc_t     acc = '0;
    logic                  ack, nack, nv_rd, nv_erase, seq_load, done, oe;
    logic                  page_erase = 1'b0;
    logic [3:0]            page = 4'h0;
    logic [3:0]            erase_page;
    logic [2:0]            nv_addr;
    logic [7:0]            rdata, nv_rdata, margin;
    logic [7:0][7:0]       active;
    logic                  host_wr = 1'b0;
    logic [2:0]            host_idx = 3'h0;
    logic [7:0]            host_data = 8'h00;
    int                    err_count = 0;
    int                    n_checks = 0;
    int                    seq_seen = 0;
    int                    cnt;

    always #4 clk = ~clk;

    cdu_top #(.SEQ_CYCLES(SEQ)) uut (
        .clk_i(clk), .rstn_i(rstn), .supply_ok_i(supply_ok), .acc_i(acc),
        .acc_ack_o(ack), .acc_nack_o(nack), .acc_rdata_o(rdata),
        .nv_rd_o(nv_rd), .nv_addr_o(nv_addr), .nv_rdata_i(nv_rdata),
        .page_erase_i(page_erase), .page_i(page), .nv_erase_o(nv_erase),
        .nv_erase_page_o(erase_page), .active_cfg_o(active), .margin_code_o(margin),
        .margin_oe_o(oe), .seq_load_o(seq_load), .download_done_o(done));

    cdu_nv_model #(.INIT(INIT)) nv (
        .clk_i(clk), .nv_rd_i(nv_rd), .nv_addr_i(nv_addr), .nv_rdata_o(nv_rdata),
        .erase_i(nv_erase), .erase_page_i(erase_page), .host_wr_i(host_wr),
        .host_idx_i(host_idx), .host_data_i(host_data));

    always @(posedge clk) begin
        if (seq_load === 1'b1) begin
            seq_seen <= seq_seen + 1;
        end
    end

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic acc_op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic exp_ack);
        acc = '{valid: 1'b1, write: w, addr: a, wdata: d};
        #1;
        chk({ack, nack}, {exp_ack, ~exp_ack});
        @(posedge clk);
        #1;
        acc.valid = 1'b0;
        settle(1);
    endtask : acc_op

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc_op(1'b0, a, 8'h00, 1'b1);
        chk(rdata, exp);
    endtask : rd

    task automatic erase_cmd(input logic exp);
        page_erase = 1'b1;
        page = 4'h5;
        @(posedge clk);
        #1;
        page_erase = 1'b0;
        chk({nv_erase, erase_page}, {exp, exp ? 4'h5 : 4'h0});
        settle(1);
    endtask : erase_cmd

    task automatic print_verdict;
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        err_count++;
        print_verdict();
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        settle(2);
        acc_op(1'b1, 8'h00, 8'h11, 1'b0);
        supply_ok = 1'b1;
        settle(1);
        chk(done, 1'b0);
        for (int i = 0; i < 100 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(active, INIT);
        cnt = 0;
        for (int i = 0; i < 60 && seq_load !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        chk(cnt, SEQ);
        chk({margin, oe}, {8'h50, 1'b1});
        acc_op(1'b1, 8'h00, 8'h90, 1'b1);
        settle(3);
        chk({active[0], margin}, {8'h50, 8'h50});
        rd(8'h00, 8'h90);
        acc_op(1'b1, 8'h90, 8'h02, 1'b1);
        settle(3);
        chk({active[0], margin}, {8'h90, 8'h80});
        rd(8'h90, 8'h00);
        acc_op(1'b1, 8'h90, 8'h01, 1'b1);
        acc_op(1'b1, 8'h00, 8'h10, 1'b1);
        settle(3);
        chk({active[0], margin}, {8'h10, 8'h20});
        rd(8'h90, 8'h01);
        acc_op(1'b1, 8'h02, 8'h90, 1'b1);
        settle(3);
        chk(oe, 1'b0);
        erase_cmd(1'b0);
        acc_op(1'b1, 8'h90, 8'h05, 1'b1);
        erase_cmd(1'b1);
        rd(8'h55, 8'h00);
        host_wr = 1'b1;
        host_data = 8'h33;
        settle(1);
        host_wr = 1'b0;
        settle(3);
        chk(active[0], 8'h10);
        acc_op(1'b1, 8'hd8, 8'h01, 1'b1);
        settle(40);
        chk(active, {INIT[63:8], 8'h33});
        chk({margin, oe}, {8'h33, 1'b1});
        chk(seq_seen, 1);
        supply_ok = 1'b0;
        settle(5);
        chk(done, 1'b0);
        acc_op(1'b0, 8'h00, 8'h00, 1'b0);
        print_verdict();
    end
endmodule : test_config_download_update
`default_nettype wire
